//--- verilog/stoc_pkg.sv
package stoc_pkg;

  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned TICK_TIME_MS  = 100;
  localparam int unsigned TICK_CYCLES   = (TICK_TIME_MS * 1000000) / CLK_PERIOD_NS;

  localparam int unsigned CODE_W     = 6;
  localparam int unsigned ADDR_W     = 5;
  localparam int unsigned TICKS_W    = 20;
  localparam int unsigned PRESCALE_W = 24;
  localparam int unsigned TABLE_SIZE = 32;

  localparam logic [CODE_W-1:0]  CODE_INFINITE   = 6'h20;
  localparam logic [CODE_W-1:0]  CODE_RESET      = 6'h00;
  localparam logic [TICKS_W-1:0] TICKS_ONE       = 20'h0_0001;
  localparam logic [TICKS_W-1:0] TICKS_ZERO      = 20'h0_0000;

  // Sleep durations in 100 ms ticks, shortest first; the last entry is 24 hours.
  localparam logic [TICKS_W-1:0] SLEEP_TABLE [TABLE_SIZE] = '{
    20'h0_0001, 20'h0_0002, 20'h0_0003, 20'h0_0005, 20'h0_000A, 20'h0_0014, 20'h0_001E, 20'h0_0032,
    20'h0_0064, 20'h0_00C8, 20'h0_012C, 20'h0_0258, 20'h0_04B0, 20'h0_0708, 20'h0_0BB8, 20'h0_1770,
    20'h0_2328, 20'h0_2EE0, 20'h0_4650, 20'h0_5DC0, 20'h0_8CA0, 20'h0_BB80, 20'h1_1940, 20'h1_A5E0,
    20'h2_3280, 20'h3_4BC0, 20'h4_6500, 20'h5_7E40, 20'h6_9780, 20'h8_CA00, 20'hA_FC80, 20'hD_2F00
  };

  typedef enum logic [2:0] {
    ST_POR,
    ST_RES_CALC,
    ST_SHUTDOWN,
    ST_ACTIVE,
    ST_SLEEP
  } stoc_state_e;

endpackage

//--- verilog/stoc_sleep_rom.sv
`timescale 1ns/1ns
module stoc_sleep_rom
  import stoc_pkg::*;
(
  input  wire logic               mclk_i,
  input  wire logic               rst_n_i,
  input  wire logic [ADDR_W-1:0]  addr_i,
  output logic      [TICKS_W-1:0] ticks_o
);

  logic [TICKS_W-1:0] ticks_ff;

  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      ticks_ff <= TICKS_ZERO;
    else
      ticks_ff <= SLEEP_TABLE[addr_i];
  end

  assign ticks_o = ticks_ff;

endmodule

//--- verilog/stoc_top.sv
`timescale 1ns/1ns
// Notes on behaviour
// R1: At power-up, a button/sleep pin resistance above 5.5 Mohm selects serial-bus programming, otherwise resistor programming.
// R2: The sleep duration comes from the pin resistor or from the serial bus, according to the selected configuration.
// R3: In resistor mode the pin resistance is measured and the duration set before the output is touched.
// R4: The auto-start variant asserts the gated output once configuration and duration setup are done.
// R5: A falling edge on the clear input deasserts the gated output and starts the sleep countdown.
// R6: When the countdown ends, the auto-start variant asserts the gated output again.
// R7: The button-start variant leaves the output deasserted after configuration and enters shutdown.
// R8: The button-start variant keeps the output deasserted until a button closure is seen.
// R9: The duration selector offers 32 finite settings from 100 ms to 24 hours plus one unbounded setting.
// R10: The interrupt output and the clear input work only in resistor-programmed configuration.
// R11: The unbounded setting never expires, so only another wake source such as the button ends the sleep.
module stoc_top
  import stoc_pkg::*;
#(
  parameter int unsigned TICK_CYCLES_P = TICK_CYCLES
)
(
  input  wire logic              mclk_i,
  input  wire logic              rst_n_i,
  input  wire logic              auto_variant_i,
  input  wire logic              res_above_thr_i,
  input  wire logic              res_valid_i,
  input  wire logic [CODE_W-1:0] res_code_i,
  input  wire logic              serial_wr_i,
  input  wire logic [CODE_W-1:0] serial_code_i,
  input  wire logic              serial_sleep_i,
  input  wire logic              button_sleep_pin_i,
  input  wire logic              clear_falling_input_i,
  output logic                   gated_out_o,
  output logic                   interrupt_o,
  output logic                   cfg_serial_o
);

  stoc_state_e       state_ff;
  stoc_state_e       nxt_state;
  logic [1:0]        btn_sync_ff;
  logic [1:0]        clr_sync_ff;
  logic [1:0]        thr_sync_ff;
  logic              clr_prev_ff;
  logic              auto_ff;
  logic              cfg_serial_ff;
  logic              gated_ff;
  logic              int_ff;
  logic [CODE_W-1:0] sleep_code_ff;
  logic [TICKS_W-1:0] remain_ff;
  logic [PRESCALE_W-1:0] prescale_ff;
  logic [TICKS_W-1:0] rom_ticks;
  logic              btn_press;
  logic              clr_fall;
  logic              go_sleep;
  logic              tick;
  logic              expire;
  logic              cfg_done;

  // Pin inputs pass two flops; only the second stage is read.
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      btn_sync_ff <= 2'h0;
      clr_sync_ff <= 2'h3;
      clr_prev_ff <= 1'b1;
    end
    else
    begin
      btn_sync_ff <= {btn_sync_ff[0], button_sleep_pin_i};
      clr_sync_ff <= {clr_sync_ff[0], clear_falling_input_i};
      clr_prev_ff <= clr_sync_ff[1];
    end
  end

  // The threshold synchroniser has no reset, so it already holds the pin level
  // when the strap is caught on the first edge after reset release.
  always_ff @(posedge mclk_i)
  begin
    thr_sync_ff <= {thr_sync_ff[0], res_above_thr_i};
  end

  assign btn_press = btn_sync_ff[1];
  // The clear input is ignored in serial configuration.
  assign clr_fall  = clr_prev_ff & ~clr_sync_ff[1] & ~cfg_serial_ff; // R10
  assign go_sleep  = cfg_serial_ff ? serial_sleep_i : clr_fall; // R5
  assign cfg_done  = cfg_serial_ff | res_valid_i; // R3

  // Straps are caught in the first clocked state after reset release.
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      auto_ff       <= 1'b0;
      cfg_serial_ff <= 1'b0;
    end
    else if (state_ff == ST_POR)
    begin
      auto_ff       <= auto_variant_i;
      cfg_serial_ff <= thr_sync_ff[1]; // R1
    end
  end

  // Serial writes are accepted in every state except ST_POR in serial mode; codes above the unbounded one are clamped.
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      sleep_code_ff <= CODE_RESET;
    else if (state_ff == ST_RES_CALC && !cfg_serial_ff && res_valid_i)
      sleep_code_ff <= (res_code_i > CODE_INFINITE) ? CODE_INFINITE : res_code_i; // R2 R9
    else if (cfg_serial_ff && serial_wr_i && state_ff != ST_POR)
      sleep_code_ff <= (serial_code_i > CODE_INFINITE) ? CODE_INFINITE : serial_code_i; // R2 R9
  end

  stoc_sleep_rom u_rom
  (
    .mclk_i  (mclk_i),
    .rst_n_i (rst_n_i),
    .addr_i  (sleep_code_ff[ADDR_W-1:0]),
    .ticks_o (rom_ticks)
  );

  assign tick   = (prescale_ff == PRESCALE_W'(TICK_CYCLES_P - 1));
  assign expire = (state_ff == ST_SLEEP) && tick && (remain_ff == TICKS_ONE)
                  && (sleep_code_ff != CODE_INFINITE); // R11

  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      prescale_ff <= '0;
    else if (state_ff != ST_SLEEP || tick)
      prescale_ff <= '0;
    else
      prescale_ff <= prescale_ff + 1'b1;
  end

  // The table read is registered, so a code written in ST_ACTIVE reaches remain_ff only two edges later.
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      remain_ff <= TICKS_ZERO;
    else if (state_ff == ST_ACTIVE)
      remain_ff <= rom_ticks; // R5
    else if (state_ff == ST_SLEEP && tick && remain_ff != TICKS_ONE)
      remain_ff <= remain_ff - 1'b1;
  end

  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      ST_POR:
        nxt_state = ST_RES_CALC;
      ST_RES_CALC:
        if (cfg_done)
          nxt_state = auto_ff ? ST_ACTIVE : ST_SHUTDOWN; // R4 R7
      ST_SHUTDOWN:
        if (btn_press)
          nxt_state = ST_ACTIVE; // R8
      ST_ACTIVE:
        if (go_sleep)
          nxt_state = ST_SLEEP; // R5
      ST_SLEEP:
        if (btn_press)
          nxt_state = ST_ACTIVE; // R11
        else if (expire)
          nxt_state = auto_ff ? ST_ACTIVE : ST_SHUTDOWN; // R6
      default:
        nxt_state = ST_POR;
    endcase
  end

  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      state_ff <= ST_POR;
    else
      state_ff <= nxt_state;
  end

  // The output follows the next state so it changes on the same edge as the state.
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      gated_ff <= 1'b0;
    else
      gated_ff <= (nxt_state == ST_ACTIVE); // R4 R6
  end

  // Interrupt flags a countdown expiry in resistor configuration; a clear edge in the same cycle loses to the new event.
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      int_ff <= 1'b0;
    else if (expire && !cfg_serial_ff)
      int_ff <= 1'b1; // R10
    else if (clr_fall)
      int_ff <= 1'b0;
  end

  assign gated_out_o  = gated_ff;
  assign interrupt_o  = int_ff;
  assign cfg_serial_o = cfg_serial_ff;

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);

  chk_cfg_select: assert property ((state_ff == ST_POR) |=> cfg_serial_ff == $past(thr_sync_ff[1])) // R1
    else $error("configuration choice does not follow the threshold input");
  chk_code_source: assert property ((state_ff == ST_RES_CALC && !cfg_serial_ff && res_valid_i
                                     && res_code_i <= CODE_INFINITE) |=> sleep_code_ff == $past(res_code_i)) // R2
    else $error("resistor code was not stored");
  chk_calc_quiet: assert property ((state_ff == ST_RES_CALC && !cfg_done) |=> !gated_out_o) // R3
    else $error("output moved before measurement finished");
  chk_auto_start: assert property ((state_ff == ST_RES_CALC && cfg_done && auto_ff)
                                   |=> gated_out_o && state_ff == ST_ACTIVE) // R4
    else $error("auto-start variant did not assert the output");
  chk_clear_off: assert property ((state_ff == ST_ACTIVE && clr_fall) |=> !gated_out_o && state_ff == ST_SLEEP) // R5
    else $error("clear edge did not start the sleep");
  chk_expire_on: assert property ((expire && auto_ff && !btn_press) |=> gated_out_o ##1 remain_ff == rom_ticks) // R6
    else $error("output not reasserted at countdown end");
  chk_button_shut: assert property ((state_ff == ST_RES_CALC && cfg_done && !auto_ff)
                                    |=> state_ff == ST_SHUTDOWN && !gated_out_o) // R7
    else $error("button-start variant did not enter shutdown");
  chk_shut_hold: assert property ((state_ff == ST_SHUTDOWN && !btn_press) |=> !gated_out_o) // R8
    else $error("output asserted in shutdown without a button press");
  chk_code_range: assert property (sleep_code_ff <= CODE_INFINITE) // R9
    else $error("sleep code out of range");
  chk_serial_clear: assert property ((cfg_serial_ff && state_ff == ST_ACTIVE && !serial_sleep_i)
                                     |=> gated_out_o && !interrupt_o) // R10
    else $error("clear input acted in serial configuration");
  chk_infinite_hold: assert property ((state_ff == ST_SLEEP && sleep_code_ff == CODE_INFINITE && !btn_press)
                                      |=> state_ff == ST_SLEEP && !gated_out_o) // R11
    else $error("unbounded sleep ended without a wake source");

  cov_auto_cycle: cover property ((state_ff == ST_SLEEP) ##1 (state_ff == ST_ACTIVE && auto_ff));
  cov_button_wake: cover property ((state_ff == ST_SHUTDOWN) ##1 (state_ff == ST_ACTIVE));
  cov_serial_sleep: cover property (cfg_serial_ff && state_ff == ST_ACTIVE && serial_sleep_i);
  cov_interrupt: cover property ($rose(interrupt_o));

endmodule

//--- tb/stoc_mcu_model.sv
`timescale 1ns/1ns
module stoc_mcu_model
(
  input  wire logic mclk_i,
  input  wire logic en_i,
  input  wire logic gated_out_i,
  output logic      clear_falling_input_o
);
  // The clear line has a pull-up, so it idles high while the processor is unpowered.
  initial
  begin
    clear_falling_input_o = 1'b1;
    forever
    begin
      @(posedge gated_out_i);
      repeat (6) @(posedge mclk_i);
      #1;
      if (en_i === 1'b1)
        clear_falling_input_o = 1'b0;
      repeat (4) @(posedge mclk_i);
      #1;
      clear_falling_input_o = 1'b1;
    end
  end
endmodule

//--- tb/tb_sleep_timer_onoff_control.sv
`timescale 1ns/1ns
module tb_sleep_timer_onoff_control;
  import stoc_pkg::*;
  localparam int TK = 4;
  logic              mclk_i;
  logic              rst_n_i;
  logic              auto_i;
  logic              thr_i;
  logic              rv_i;
  logic              swr_i;
  logic              ssl_i;
  logic              btn_i;
  logic              clr;
  logic              en;
  logic [CODE_W-1:0] rc_i;
  logic [CODE_W-1:0] sc_i;
  logic              gated_out_o;
  logic              interrupt_o;
  logic              cfg_serial_o;
  logic [31:0]       lfsr = 32'h0000_3da6;
  int                fails = 0;
  int                checks_done = 0;
  int                cyc = 0;
  int                n;
  int                code;

  stoc_top #(.TICK_CYCLES_P(TK)) DUT (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .auto_variant_i(auto_i),
    .res_above_thr_i(thr_i), .res_valid_i(rv_i), .res_code_i(rc_i), .serial_wr_i(swr_i),
    .serial_code_i(sc_i), .serial_sleep_i(ssl_i), .button_sleep_pin_i(btn_i),
    .clear_falling_input_i(clr), .gated_out_o(gated_out_o), .interrupt_o(interrupt_o),
    .cfg_serial_o(cfg_serial_o));
  stoc_mcu_model mcu (.mclk_i(mclk_i), .en_i(en), .gated_out_i(gated_out_o), .clear_falling_input_o(clr));

  initial
  begin
    mclk_i = 1'b0;
    forever #5 mclk_i = ~mclk_i;
  end

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic step(input int k);
    repeat (k) @(posedge mclk_i);
    #1;
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    checks_done++;
    if (got !== exp)
    begin
      fails++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Polling starts on the edge of sleep entry, so the count equals ticks times tick length.
  task automatic chk_len(input int got, input int exp);
    checks_done++;
    if (got != exp)
    begin
      fails++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wait_out(input logic v, input int lim);
    n = 0;
    while (gated_out_o !== v && n < lim)
    begin
      step(1);
      n++;
    end
  endtask

  task automatic start(input logic a, input logic t, input int c);
    rst_n_i = 1'b0;
    auto_i  = a;
    thr_i   = t;
    rc_i    = c[CODE_W-1:0];
    rv_i    = 1'b0;
    en      = 1'b1;
    step(8);
    rst_n_i = 1'b1;
    step(4);
    chk_bit(gated_out_o, a & t);
    rv_i = 1'b1;
    step(1);
  endtask

  task automatic press();
    en    = 1'b0;
    btn_i = 1'b1;
    wait_out(1'b1, 6);
    btn_i = 1'b0;
  endtask

  always @(posedge mclk_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      fails++;
      test_done();
    end
  end

  initial
  begin
    {auto_i, thr_i, swr_i, ssl_i, btn_i, en} = 6'h0_0;
    rv_i = 1'b0;
    rc_i = 6'h00;
    sc_i = 6'h00;
    rst_n_i = 1'b0;
    for (int k = 0; k < 3; k++)
    begin
      lfsr = lfsr_next(lfsr);
      code = int'(lfsr[1:0]);
      start(1'b1, 1'b0, code);
      chk_bit(gated_out_o, 1'b1);
      chk_bit(cfg_serial_o, 1'b0);
      wait_out(1'b0, 40);
      chk_bit(gated_out_o, 1'b0);
      wait_out(1'b1, 100);
      chk_len(n, int'(SLEEP_TABLE[code]) * TK);
      chk_bit(interrupt_o, 1'b1);
      wait_out(1'b0, 40);
      chk_bit(interrupt_o, 1'b0);
      $display("resistor test %0d done", k);
    end
    start(1'b1, 1'b1, 0);
    chk_bit(cfg_serial_o, 1'b1);
    chk_bit(gated_out_o, 1'b1);
    lfsr = lfsr_next(lfsr);
    code = int'(lfsr[1:0]);
    sc_i = code[CODE_W-1:0];
    swr_i = 1'b1;
    step(1);
    swr_i = 1'b0;
    step(12);
    chk_bit(gated_out_o, 1'b1);
    ssl_i = 1'b1;
    step(1);
    ssl_i = 1'b0;
    wait_out(1'b0, 3);
    chk_bit(gated_out_o, 1'b0);
    wait_out(1'b1, 100);
    chk_len(n, int'(SLEEP_TABLE[code]) * TK);
    chk_bit(interrupt_o, 1'b0);
    $display("serial test done");
    start(1'b0, 1'b0, 1);
    chk_bit(gated_out_o, 1'b0);
    step(30);
    chk_bit(gated_out_o, 1'b0);
    press();
    chk_bit(gated_out_o, 1'b1);
    $display("button test done");
    start(1'b1, 1'b0, 32);
    wait_out(1'b0, 40);
    step(300);
    chk_bit(gated_out_o, 1'b0);
    press();
    chk_bit(gated_out_o, 1'b1);
    $display("unbounded test done");
    step(20);
    test_done();
  end
endmodule
